// file: hw/lrb_map.svh
`ifndef LRB_MAP_SVH
`define LRB_MAP_SVH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define LRB_ADDR_VCODE0   8'h12
`define LRB_ADDR_VCODE1   8'h13
`define LRB_ADDR_VCODE2   8'h14
`define LRB_ADDR_VCODE3   8'h16
`define LRB_ADDR_VCODE4   8'h17
`define LRB_ADDR_CTL3     8'h5e
`define LRB_ADDR_CTL4     8'h60
`define LRB_ADDR_CTL1     8'h61
`define LRB_ADDR_CTL0     8'h65
`define LRB_ADDR_CTL2     8'h66
`define LRB_ADDR_SLOT0    8'hed
`define LRB_ADDR_SLOT1    8'hee
`define LRB_ADDR_SLOT2    8'hef
`define LRB_ADDR_SLOT3    8'hf0
`define LRB_ADDR_SLOT4    8'hf1

// ---------------------------------------------------------------------------
// Field positions, masks and reset values
// ---------------------------------------------------------------------------
`define LRB_CTL_ON_BIT    0
`define LRB_CTL_SEL_BIT   1
`define LRB_CTL_MASK      8'h03
`define LRB_CTL_RESET     8'h00
`define LRB_SLOT_MASK     8'h3f
`define LRB_VCODE_MASK01  8'h1f
`define LRB_VCODE_MASK34  8'h3f
`define LRB_VCODE_MAX     8'h1a
`define LRB_PASS_MIN      8'h1b
`define LRB_SLOT_OFF      4'hf
`define LRB_UNMAPPED_RD   8'h00

`endif

// file: hw/lrb_pkg.sv
package lrb_pkg;

  typedef enum logic [1:0] {
    LRB_CLASS_A  = 2'b00,
    LRB_CLASS_U  = 2'b01,
    LRB_CLASS_S  = 2'b10,
    LRB_CLASS_SX = 2'b11
  } lrb_class_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lrb_req_t;

  typedef struct packed {
    logic       rail_on;
    logic [5:0] vcode;
    logic       pass_switch;
    lrb_class_t rail_class;
    logic [3:0] delay_slot;
    logic       auto_seq;
  } lrb_rail_t;

endpackage

// file: hw/lrb_rail_ctrl.sv
`timescale 1ns/100ps
`include "lrb_map.svh"

// ---------------------------------------------------------------------------
// One rail: on/off source selection and field decode
// ---------------------------------------------------------------------------
module lrb_rail_ctrl #(
  parameter bit INVERT_SEQ = 1'b0,
  parameter bit HAS_PASS   = 1'b1
) (
  // Register contents
  input  wire logic [7:0]        ctl,
  input  wire logic [7:0]        vcode,
  input  wire logic [7:0]        slot,
  // Sequencer request
  input  wire logic              seq_req,
  // Decoded rail state
  output lrb_pkg::lrb_rail_t     rail
);

  logic seq_on;

  // Rails 3 and 4 follow the opposite sequencer polarity.
  assign seq_on = INVERT_SEQ ? ~seq_req : seq_req;

  always_comb begin
    rail = '0;
    if (ctl[`LRB_CTL_SEL_BIT]) begin
      rail.rail_on = ctl[`LRB_CTL_ON_BIT];
    end else begin
      rail.rail_on = seq_on;
    end
    rail.vcode = vcode[5:0];
    rail.pass_switch = HAS_PASS && (vcode >= `LRB_PASS_MIN);
    rail.rail_class = lrb_pkg::lrb_class_t'(slot[5:4]);
    rail.delay_slot = slot[3:0];
    rail.auto_seq = (slot[3:0] != `LRB_SLOT_OFF);
  end

endmodule // lrb_rail_ctrl

// file: hw/lrb_bank.sv
`timescale 1ns/100ps
`include "lrb_map.svh"

// Overview of operation
// - Select bit zero: sequencer drives rail.
// - Select bit one: enable bit drives rail.
// - Enable bit 0 off, 1 on.
// - Rails 0-2: sequencer request high means on.
// - Rails 3-4: sequencer request low means on.
// - Rails 0-2: codes 0-26 regulate, 27+ pass.
// - Rails 3-4: codes 0-0x3f regulate linearly, no pass.
// - Slot bits 5:4 give rail class.
// - Slot bits 3:0 pick group, 0xf disables.

module lrb_bank #(
  parameter int NRAIL = 5,
  parameter logic [39:0] OTP_VCODE = 40'h0808_1414_14,
  parameter logic [39:0] OTP_SLOT  = 40'h0f0f_0f0f_0f
) (
  // Clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  // Register access from the serial interface engine
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic      [7:0]         REG_RDATA,
  output logic                    REG_HIT,
  // Factory configuration
  input  wire logic [39:0]        OTP_VCODE_IN,
  input  wire logic [39:0]        OTP_SLOT_IN,
  input  wire logic               OTP_VALID,
  // Sequencer
  input  wire logic [4:0]         SEQ_REQ,
  // Rail outputs
  output logic      [4:0]         RAIL_ON,
  output logic      [29:0]        RAIL_VCODE,
  output logic      [4:0]         RAIL_PASS,
  output logic      [9:0]         RAIL_CLASS,
  output logic      [19:0]        RAIL_SLOT,
  output logic      [4:0]         RAIL_AUTO
);

  // -------------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------------
  logic [7:0] ctl_reg   [5];
  logic [7:0] vcode_reg [5];
  logic [7:0] slot_reg  [5];
  logic       otp_done_reg;
  lrb_pkg::lrb_req_t req;
  lrb_pkg::lrb_rail_t rail_st [5];

  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  function automatic logic [7:0] ctl_addr(input int i);
    case (i)
      0: ctl_addr = `LRB_ADDR_CTL0;
      1: ctl_addr = `LRB_ADDR_CTL1;
      2: ctl_addr = `LRB_ADDR_CTL2;
      3: ctl_addr = `LRB_ADDR_CTL3;
      default: ctl_addr = `LRB_ADDR_CTL4;
    endcase
  endfunction

  function automatic logic [7:0] vcode_addr(input int i);
    case (i)
      0: vcode_addr = `LRB_ADDR_VCODE0;
      1: vcode_addr = `LRB_ADDR_VCODE1;
      2: vcode_addr = `LRB_ADDR_VCODE2;
      3: vcode_addr = `LRB_ADDR_VCODE3;
      default: vcode_addr = `LRB_ADDR_VCODE4;
    endcase
  endfunction

  function automatic logic [7:0] slot_addr(input int i);
    case (i)
      0: slot_addr = `LRB_ADDR_SLOT0;
      1: slot_addr = `LRB_ADDR_SLOT1;
      2: slot_addr = `LRB_ADDR_SLOT2;
      3: slot_addr = `LRB_ADDR_SLOT3;
      default: slot_addr = `LRB_ADDR_SLOT4;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // Factory load
  // -------------------------------------------------------------------------
  // The factory values are latched once after reset release, when the
  // fuse reader reports them valid; host writes to the code and slot registers are ignored until then.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      otp_done_reg <= 1'b0;
    end else if (OTP_VALID) begin
      otp_done_reg <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Per-rail registers and decode
  // -------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_rail
      localparam logic [7:0] VMASK =
        (g < 3) ? `LRB_VCODE_MASK01 : `LRB_VCODE_MASK34;

      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          ctl_reg[g] <= `LRB_CTL_RESET;
        end else if (req.wr && req.addr == ctl_addr(g)) begin
          ctl_reg[g] <= req.wdata & `LRB_CTL_MASK;
        end
      end

      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          vcode_reg[g] <= 8'h00;
          slot_reg[g]  <= 8'h00;
        end else if (!otp_done_reg) begin
          if (OTP_VALID) begin
            vcode_reg[g] <= OTP_VCODE_IN[g*8 +: 8] & VMASK;
            slot_reg[g]  <= OTP_SLOT_IN[g*8 +: 8] & `LRB_SLOT_MASK;
          end
        end else if (req.wr) begin
          if (req.addr == vcode_addr(g)) begin
            vcode_reg[g] <= req.wdata & VMASK;
          end
          if (req.addr == slot_addr(g)) begin
            slot_reg[g] <= req.wdata & `LRB_SLOT_MASK;
          end
        end
      end

      lrb_rail_ctrl #(
        .INVERT_SEQ (g >= 3),
        .HAS_PASS   (g < 3)
      ) u_rail (
        .ctl     (ctl_reg[g]),
        .vcode   (vcode_reg[g]),
        .slot    (slot_reg[g]),
        .seq_req (SEQ_REQ[g]),
        .rail    (rail_st[g])
      );

      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          RAIL_ON[g]             <= 1'b0;
          RAIL_VCODE[g*6 +: 6]   <= 6'h00;
          RAIL_PASS[g]           <= 1'b0;
          RAIL_CLASS[g*2 +: 2]   <= 2'b00;
          RAIL_SLOT[g*4 +: 4]    <= 4'h0;
          RAIL_AUTO[g]           <= 1'b0;
        end else begin
          RAIL_ON[g]             <= rail_st[g].rail_on;
          RAIL_VCODE[g*6 +: 6]   <= rail_st[g].vcode;
          RAIL_PASS[g]           <= rail_st[g].pass_switch;
          RAIL_CLASS[g*2 +: 2]   <= rail_st[g].rail_class;
          RAIL_SLOT[g*4 +: 4]    <= rail_st[g].delay_slot;
          RAIL_AUTO[g]           <= rail_st[g].auto_seq;
        end
      end

      a_manual_on: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        ctl_reg[g][1] |=> RAIL_ON[g] == $past(ctl_reg[g][0]))
        else $error("manual rail state not followed");
      a_seq_follow: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !ctl_reg[g][1] |=>
          RAIL_ON[g] == ($past(SEQ_REQ[g]) ^ (g >= 3)))
        else $error("sequencer rail state wrong");
      a_slot_off: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        slot_reg[g][3:0] == 4'hf |=> !RAIL_AUTO[g])
        else $error("disabled slot still automatic");
      a_class_out: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        1'b1 |=> RAIL_CLASS[g*2 +: 2] == $past(slot_reg[g][5:4]))
        else $error("rail class mismatch");
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  logic [7:0] rdata_next;
  logic       hit_next;

  always_comb begin
    rdata_next = `LRB_UNMAPPED_RD;
    hit_next   = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (req.addr == ctl_addr(i)) begin
        rdata_next = ctl_reg[i];
        hit_next   = 1'b1;
      end
      if (req.addr == vcode_addr(i)) begin
        rdata_next = vcode_reg[i];
        hit_next   = 1'b1;
      end
      if (req.addr == slot_addr(i)) begin
        rdata_next = slot_reg[i];
        hit_next   = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
      REG_HIT   <= 1'b0;
    end else if (req.rd) begin
      REG_RDATA <= rdata_next;
      REG_HIT   <= hit_next;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_ctl_reserved: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    REG_RD && REG_ADDR == `LRB_ADDR_CTL0 |=> REG_RDATA[7:2] == 6'h00)
    else $error("reserved control bits not zero");
  a_pass_mode: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    vcode_reg[0] >= 8'h1b |=> RAIL_PASS[0])
    else $error("pass switch not entered");
  a_no_pass34: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    !RAIL_PASS[3] && !RAIL_PASS[4])
    else $error("pass switch on rail 3 or 4");
  a_otp_load: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    OTP_VALID && !otp_done_reg |=>
      slot_reg[1] == ($past(OTP_SLOT_IN[15:8]) & 8'h3f))
    else $error("factory slot not loaded");

  c_manual:  cover property (@(posedge CLOCK) ctl_reg[0][1] && RAIL_ON[0]);
  c_seq_inv: cover property (@(posedge CLOCK) !ctl_reg[3][1] && RAIL_ON[3]);
  c_pass:    cover property (@(posedge CLOCK) RAIL_PASS[2]);

endmodule // lrb_bank

// file: tb/lrb_host.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------------------
// Host side of the register strobes
// ---------------------------------------------------------------------------
module lrb_host (
  // Clock
  input  wire logic       clk,
  // Strobes toward the bank
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  // Read return
  input  wire logic [7:0] rdata,
  input  wire logic       hit
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Released lines show the inverse so stale values cannot pass for data.
  // An idle cycle follows each access so a strobe never drops and rises in
  // the same time step.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #5;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
    @(posedge clk);
    #5;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #5;
    rd = 1'b0;
    addr = ~a;
    d = rdata;
    h = hit;
    @(posedge clk);
    #5;
  endtask
endmodule // lrb_host

// file: tb/lrb_bank_tb.sv
`timescale 1ns/100ps

module lrb_bank_tb;
  localparam logic [39:0] OTP_V = 40'h10_1a_1c_05_14;
  localparam logic [39:0] OTP_S = 40'h3f_2e_1d_0c_3f;
  logic [7:0]  ctl_a [5] = '{8'h65, 8'h61, 8'h66, 8'h5e, 8'h60};
  logic [7:0]  vc_a  [5] = '{8'h12, 8'h13, 8'h14, 8'h16, 8'h17};
  logic [7:0]  sl_a  [5] = '{8'hed, 8'hee, 8'hef, 8'hf0, 8'hf1};
  logic        clock, rst_b, otp_valid, reg_wr, reg_rd, reg_hit, h;
  logic [4:0]  seq_req, rail_on, rail_pass, rail_auto;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [29:0] rail_vcode;
  logic [9:0]  rail_class;
  logic [19:0] rail_slot;
  int          errors, comparisons;

  lrb_host host (.clk(clock), .addr(reg_addr), .wdata(reg_wdata),
    .wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata), .hit(reg_hit));

  lrb_bank dut (.CLOCK(clock), .RST_B(rst_b), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .REG_HIT(reg_hit), .OTP_VCODE_IN(OTP_V),
    .OTP_SLOT_IN(OTP_S), .OTP_VALID(otp_valid), .SEQ_REQ(seq_req),
    .RAIL_ON(rail_on), .RAIL_VCODE(rail_vcode), .RAIL_PASS(rail_pass),
    .RAIL_CLASS(rail_class), .RAIL_SLOT(rail_slot), .RAIL_AUTO(rail_auto));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      host.read(ctl_a[i], d, h);
      check({h, d}, 9'h100);
      host.read(vc_a[i], d, h);
      check(d, OTP_V[8*i+:8]);
      host.read(sl_a[i], d, h);
      check(d, OTP_S[8*i+:8]);
    end
    check(rail_pass, 5'b00100);
    check(rail_auto, 5'b01110);
    check(rail_vcode, {6'h10, 6'h1a, 6'h1c, 6'h05, 6'h14});
    check(rail_class, 10'h393);
    check(rail_slot, 20'hfedcf);
  endtask

  // Sequencer stand-in: each class follows its own sleep line and the A
  // class stays requested; the classes are the factory ones.
  task automatic drive_sleep(input logic s3_n, input logic s4_n,
                             input logic s0ix_n);
    for (int i = 0; i < 5; i++) begin
      case (OTP_S[8*i+4 +: 2])
        2'h1:    seq_req[i] = s4_n;
        2'h2:    seq_req[i] = s3_n;
        2'h3:    seq_req[i] = s0ix_n;
        default: seq_req[i] = 1'b1;
      endcase
    end
    step(3);
  endtask

  task automatic t_sleep;
    drive_sleep(1'b1, 1'b1, 1'b1);
    check(rail_on, 5'b00111);
    drive_sleep(1'b0, 1'b1, 1'b1);
    check(rail_on, 5'b01111);
    drive_sleep(1'b1, 1'b0, 1'b0);
    check(rail_on, 5'b10010);
  endtask

  // A second reset in mid-run must clear the controls and reload the
  // factory codes over whatever the host wrote.
  task automatic t_reset_again;
    seq_req = 5'h00;
    rst_b = 1'b0;
    step(2);
    check(rail_on, 5'h00);
    rst_b = 1'b1;
    step(3);
    check(rail_on, 5'b11000);
    t_reset();
  endtask

  task automatic set_ctl(input logic [7:0] v);
    for (int i = 0; i < 5; i++) host.write(ctl_a[i], v);
    step(2);
  endtask

  task automatic t_source;
    seq_req = 5'h00;
    step(3);
    check(rail_on, 5'b11000);
    seq_req = 5'h1f;
    step(3);
    check(rail_on, 5'b00111);
    set_ctl(8'h02);
    check(rail_on, 5'h00);
    seq_req = 5'h00;
    step(3);
    check(rail_on, 5'h00);
    set_ctl(8'hff);
    check(rail_on, 5'h1f);
    host.read(ctl_a[3], d, h);
    check(d, 8'h03);
    seq_req = 5'h1f;
    set_ctl(8'h01);
    check(rail_on, 5'b00111);
  endtask

  task automatic t_vcode;
    host.write(8'h12, 8'hff);
    host.read(8'h12, d, h);
    check(d, 8'h1f);
    check({rail_pass[0], rail_vcode[5:0]}, 7'h5f);
    host.write(8'h12, 8'h1a);
    step(2);
    check({rail_pass[0], rail_vcode[5:0]}, 7'h1a);
    host.write(8'h13, 8'h1b);
    step(2);
    check(rail_pass[1], 1'b1);
    host.write(8'h16, 8'hff);
    host.read(8'h16, d, h);
    check(d, 8'h3f);
    check({rail_pass[3], rail_vcode[23:18]}, 7'h3f);
  endtask

  task automatic t_slot;
    for (int c = 0; c < 4; c++) begin
      host.write(8'hed, {2'b11, c[1:0], 4'he});
      host.read(8'hed, d, h);
      check(d, {2'b00, c[1:0], 4'he});
      check({rail_class[1:0], rail_slot[3:0], rail_auto[0]},
            {c[1:0], 4'he, 1'b1});
    end
    host.write(8'hed, 8'h0f);
    step(2);
    check({rail_slot[3:0], rail_auto[0]}, 5'h1e);
    host.read(8'h15, d, h);
    check({h, d}, 9'h000);
  endtask

  // ---------------------------------------------------------------------------
  // Clock, reset and run
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    otp_valid = 1'b0;
    seq_req = 5'h00;
    step(20);
    rst_b = 1'b1;
    step(1);
    otp_valid = 1'b1;
    step(3);
    t_reset();
    t_sleep();
    t_source();
    t_vcode();
    t_slot();
    t_reset_again();
    tally_and_finish();
  end
endmodule // lrb_bank_tb
